// file: rtl/pcer_pkg.sv
// Package: offsets, field layouts, reset values and timing for pcer block
package pcer_pkg;
  // Register byte offsets
  localparam logic [7:0] EEPROM_ACCESS_OFFSET = 8'hdc;
  localparam logic [7:0] CAP_HEADER_OFFSET = 8'he0;
  localparam logic [7:0] DEV_CAP_OFFSET = 8'he4;
  // Override port for strap/SMBus/EEPROM loaded defaults
  localparam logic [7:0] HWINIT_OVERRIDE_OFFSET = 8'hf0;

  // EEPROM access dword fields
  localparam int START_BIT = 0;
  localparam int COMMAND_BIT = 1;
  localparam int ERROR_BIT = 2;
  localparam int ADDR_LSB = 9;
  localparam int ADDR_MSB = 15;
  localparam int DATA_LSB = 16;
  localparam int DATA_MSB = 31;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;

  // Capability header fields
  localparam logic [7:0] CAP_ID_VALUE = 8'h10;
  localparam logic [7:0] NEXT_PTR_VALUE = 8'h00;
  localparam logic [3:0] CAP_VERSION_VALUE = 4'h1;
  localparam logic [3:0] PORT_TYPE_UP = 4'h5;
  localparam logic [3:0] PORT_TYPE_DOWN = 4'h6;
  localparam logic [4:0] MSG_NUMBER_VALUE = 5'h00;

  // Device capabilities fields and defaults
  localparam logic [2:0] MAX_PAYLOAD_RESET = 3'h1;
  localparam logic [1:0] PHANTOM_VALUE = 2'h0;
  localparam logic EXT_TAG_VALUE = 1'b0;
  localparam logic [2:0] LATENCY_RESET = 3'h0;
  localparam logic ROLE_ERR_RESET = 1'b1;
  localparam logic [7:0] SLOT_POWER_VALUE_RESET = 8'h00;
  localparam logic [1:0] SLOT_POWER_SCALE_RESET = 2'h0;

  // Override register fields
  localparam int OVR_PAYLOAD_LSB = 0;
  localparam int OVR_PAYLOAD_MSB = 2;
  localparam int OVR_ROLE_BIT = 3;
  localparam int OVR_SLOT_BIT = 4;

  // EEPROM serial clock: primary clock divided by 1024
  localparam int SERIAL_DIVIDE = 1024;
  localparam int FRAME_BITS = 27;

  typedef enum logic [1:0] {
    PCER_IDLE = 2'b00,
    PCER_SHIFT = 2'b01,
    PCER_DONE = 2'b10
  } pcer_state_t;
endpackage : pcer_pkg

// file: rtl/pcer_serial_engine.sv
// Serial engine moving one word frame to or from the EEPROM
`timescale 1ns/10ps
module pcer_serial_engine #(
  parameter int DIVIDE = pcer_pkg::SERIAL_DIVIDE
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic go_in,
  input wire logic write_in,
  input wire logic [6:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out,
  output logic sda_oe_out,
  output logic done_out,
  output logic nack_out,
  output logic [15:0] rdata_out
);
  // ---------------------------------------------------------------
  // Frame: command bit, 7 address bits, ack slot, 16 data bits, ack, trailing bit
  // ---------------------------------------------------------------
  localparam int HALF = DIVIDE / 2;
  localparam int CNT_W = $clog2(DIVIDE);
  localparam logic [CNT_W-1:0] HALF_M1 = CNT_W'(HALF - 1);
  localparam logic [4:0] LAST_BIT = 5'(pcer_pkg::FRAME_BITS - 1);
  localparam logic [4:0] ACK1_BIT = 5'h08;
  localparam logic [4:0] ACK2_BIT = 5'h19;

  pcer_pkg::pcer_state_t state;
  pcer_pkg::pcer_state_t next_state;
  logic [CNT_W-1:0] div;
  logic [4:0] bit_idx;
  logic [26:0] frame;
  logic is_write;
  logic sda_s1;
  logic sda_s2;
  wire half_tick = (div == HALF_M1);
  wire rise_tick = half_tick & ~scl_out;
  wire fall_tick = half_tick & scl_out;
  wire ack_slot = (bit_idx == ACK1_BIT) | (bit_idx == ACK2_BIT);
  wire drive_slot = ~ack_slot & (is_write | (bit_idx < ACK1_BIT));

  always_comb begin
    next_state = state;
    case (state)
      pcer_pkg::PCER_IDLE: begin
        if (go_in) begin
          next_state = pcer_pkg::PCER_SHIFT;
        end
      end
      pcer_pkg::PCER_SHIFT: begin
        if (fall_tick && bit_idx == LAST_BIT) begin
          next_state = pcer_pkg::PCER_DONE;
        end
      end
      pcer_pkg::PCER_DONE: next_state = pcer_pkg::PCER_IDLE;
      default: next_state = pcer_pkg::PCER_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= pcer_pkg::PCER_IDLE;
      div <= '0;
      bit_idx <= '0;
      frame <= '0;
      is_write <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
      done_out <= 1'b0;
      nack_out <= 1'b0;
      rdata_out <= '0;
      sda_s1 <= 1'b0;
      sda_s2 <= 1'b0;
    end else begin
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      state <= next_state;
      done_out <= (state == pcer_pkg::PCER_SHIFT) &&
                  (next_state == pcer_pkg::PCER_DONE);
      case (state)
        pcer_pkg::PCER_IDLE: begin
          scl_out <= 1'b0;
          sda_oe_out <= 1'b0;
          div <= '0;
          bit_idx <= '0;
          if (go_in) begin
            frame <= {write_in, addr_in, 1'b0, wdata_in, 1'b0, 1'b0};
            is_write <= write_in;
            nack_out <= 1'b0;
          end
        end
        pcer_pkg::PCER_SHIFT: begin
          div <= half_tick ? '0 : div + 1'b1;
          sda_oe_out <= drive_slot;
          sda_out <= frame[26];
          if (rise_tick) begin
            scl_out <= 1'b1;
          end
          // Sample at the end of the high phase, past the pin pipeline
          if (fall_tick) begin
            scl_out <= 1'b0;
            if (ack_slot && sda_s2) begin
              nack_out <= 1'b1;
            end
            if (!is_write && bit_idx > ACK1_BIT && bit_idx < ACK2_BIT) begin
              rdata_out <= {rdata_out[14:0], sda_s2};
            end
            bit_idx <= bit_idx + 1'b1;
            frame <= {frame[25:0], 1'b0};
          end
        end
        default: begin
          scl_out <= 1'b0;
          sda_oe_out <= 1'b0;
        end
      endcase
    end
  end
endmodule : pcer_serial_engine

// file: rtl/pcer_regs.sv
// Capability and EEPROM access register bank on an Avalon-MM slave
`timescale 1ns/10ps
module pcer_regs #(
  parameter bit UPSTREAM = 1'b1,
  parameter int DIVIDE = pcer_pkg::SERIAL_DIVIDE
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic slot_strap_in,
  input wire logic power_msg_in,
  input wire logic [7:0] power_value_in,
  input wire logic [1:0] power_scale_in,
  input wire logic sda_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic scl_out,
  output logic sda_out,
  output logic sda_oe_out
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic start;
  logic command;
  logic error;
  logic [6:0] ee_addr;
  logic [15:0] ee_data;
  logic [2:0] max_payload;
  logic role_err;
  logic slot_present;
  logic [7:0] slot_power_value;
  logic [1:0] slot_power_scale;
  logic strap_s1;
  logic strap_s2;
  logic strap_taken;
  logic strap_arm1;
  logic strap_arm2;
  logic msg_s1;
  logic msg_s2;
  logic msg_s3;
  logic answered;
  logic go;
  logic eng_done;
  logic eng_nack;
  logic [15:0] eng_rdata;
  logic eng_scl;
  logic eng_sda;
  logic eng_oe;

  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic en);
    merge_byte = en ? new_v : old_v;
  endfunction : merge_byte

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire req = (avs_read_in | avs_write_in) & ~answered;
  // Writes land on the edge at which waitrequest is low
  wire wr = avs_write_in & answered;
  wire hit_access = (avs_address_in == pcer_pkg::EEPROM_ACCESS_OFFSET);
  wire hit_cap = (avs_address_in == pcer_pkg::CAP_HEADER_OFFSET);
  wire hit_dev = (avs_address_in == pcer_pkg::DEV_CAP_OFFSET);
  wire hit_ovr = (avs_address_in == pcer_pkg::HWINIT_OVERRIDE_OFFSET);
  wire wr_access = wr & hit_access & UPSTREAM;
  wire wr_ovr = wr & hit_ovr;
  wire busy = start;
  wire start_req = wr_access & avs_byteenable_in[0] &
                   avs_writedata_in[pcer_pkg::START_BIT] & ~busy;
  wire [3:0] port_type = UPSTREAM ? pcer_pkg::PORT_TYPE_UP :
                                    pcer_pkg::PORT_TYPE_DOWN;
  wire slot_bit = UPSTREAM ? 1'b0 : slot_present;
  wire [7:0] low_byte = {5'h00, error, command, start};
  wire [31:0] access_word = UPSTREAM ?
                            {ee_data, ee_addr, 1'b0, low_byte} : '0;
  wire [31:0] cap_word = {2'h0, pcer_pkg::MSG_NUMBER_VALUE,
                          slot_bit, port_type,
                          pcer_pkg::CAP_VERSION_VALUE,
                          pcer_pkg::NEXT_PTR_VALUE,
                          pcer_pkg::CAP_ID_VALUE};
  wire [31:0] dev_word = {4'h0, slot_power_scale, slot_power_value,
                          2'h0, role_err, 3'h0,
                          pcer_pkg::LATENCY_RESET,
                          pcer_pkg::LATENCY_RESET,
                          pcer_pkg::EXT_TAG_VALUE,
                          pcer_pkg::PHANTOM_VALUE,
                          max_payload};
  wire [31:0] ovr_word = {27'h0, slot_present, role_err, max_payload};
  wire [31:0] next_readdata = hit_access ? access_word :
                              hit_cap ? cap_word :
                              hit_dev ? dev_word :
                              hit_ovr ? ovr_word : '0;
  wire [15:0] data_merged = {
    merge_byte(ee_data[15:8], avs_writedata_in[31:24], avs_byteenable_in[3]),
    merge_byte(ee_data[7:0], avs_writedata_in[23:16], avs_byteenable_in[2])};
  wire [7:0] addr_byte = merge_byte({ee_addr, 1'b0}, avs_writedata_in[15:8],
                                    avs_byteenable_in[1]);

  // ---------------------------------------------------------------
  // Bus answer: one wait cycle, then waitrequest low with data
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      answered <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= '0;
    end else begin
      answered <= req;
      avs_waitrequest_out <= ~req;
      if (req && avs_read_in) begin
        avs_readdata_out <= next_readdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // EEPROM access window
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      start <= 1'b0;
      command <= 1'b0;
      error <= 1'b0;
      ee_addr <= '0;
      ee_data <= '0;
      go <= 1'b0;
    end else begin
      go <= start_req;
      if (wr_access && !busy) begin
        ee_addr <= addr_byte[7:1];
        ee_data <= data_merged;
        if (avs_byteenable_in[0]) begin
          command <= avs_writedata_in[pcer_pkg::COMMAND_BIT];
        end
      end
      if (start_req) begin
        start <= 1'b1;
        error <= 1'b0;
      end else if (eng_done) begin
        start <= 1'b0;
        error <= eng_nack;
        if (!command) begin
          ee_data <= eng_rdata;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Hardware-initialised defaults and slot power capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      max_payload <= pcer_pkg::MAX_PAYLOAD_RESET;
      role_err <= pcer_pkg::ROLE_ERR_RESET;
      slot_present <= 1'b0;
      slot_power_value <= pcer_pkg::SLOT_POWER_VALUE_RESET;
      slot_power_scale <= pcer_pkg::SLOT_POWER_SCALE_RESET;
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
      strap_taken <= 1'b0;
      strap_arm1 <= 1'b0;
      strap_arm2 <= 1'b0;
      msg_s1 <= 1'b0;
      msg_s2 <= 1'b0;
      msg_s3 <= 1'b0;
    end else begin
      strap_s1 <= slot_strap_in;
      strap_s2 <= strap_s1;
      msg_s1 <= power_msg_in;
      msg_s2 <= msg_s1;
      msg_s3 <= msg_s2;
      strap_arm1 <= 1'b1;
      strap_arm2 <= strap_arm1;
      // Wait until the synchroniser holds the real strap level
      if (strap_arm2 && !strap_taken) begin
        strap_taken <= 1'b1;
        slot_present <= strap_s2;
      end else if (wr_ovr && avs_byteenable_in[0]) begin
        slot_present <= avs_writedata_in[pcer_pkg::OVR_SLOT_BIT];
      end
      if (wr_ovr && avs_byteenable_in[0]) begin
        max_payload <= avs_writedata_in[pcer_pkg::OVR_PAYLOAD_MSB:
                                        pcer_pkg::OVR_PAYLOAD_LSB];
        role_err <= avs_writedata_in[pcer_pkg::OVR_ROLE_BIT];
      end
      if (UPSTREAM && msg_s2 && !msg_s3) begin
        slot_power_value <= power_value_in;
        slot_power_scale <= power_scale_in;
      end
    end
  end

  // ---------------------------------------------------------------
  // Serial engine and pin registers
  // ---------------------------------------------------------------
  pcer_serial_engine #(
    .DIVIDE(DIVIDE)
  ) u_engine (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .go_in(go),
    .write_in(command),
    .addr_in(ee_addr),
    .wdata_in(ee_data),
    .sda_in(sda_in),
    .scl_out(eng_scl),
    .sda_out(eng_sda),
    .sda_oe_out(eng_oe),
    .done_out(eng_done),
    .nack_out(eng_nack),
    .rdata_out(eng_rdata)
  );

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      scl_out <= eng_scl;
      sda_out <= eng_sda;
      sda_oe_out <= eng_oe;
    end
  end
endmodule : pcer_regs

// file: sim/pcer_regs_assertions.sv
// Checker for the capability and EEPROM access register bank
`timescale 1ns/10ps
module pcer_regs_assertions #(
  parameter bit UPSTREAM = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out
);
  logic hdr_rd;
  logic dev_rd;
  wire logic [31:0] d = avs_readdata_out;
  wire logic ans = !avs_waitrequest_out;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Marks reads of the two capability dwords
  always_ff @(posedge clk_in) begin
    hdr_rd <= rst_n_in && avs_read_in && avs_address_in == 8'he0;
    dev_rd <= rst_n_in && avs_read_in && avs_address_in == 8'he4;
  end
  AST_ANSWER_NEXT: assert property ($rose(avs_read_in || avs_write_in)
    |=> ans) else $error("no answer one cycle after request");
  AST_ANSWER_ONE: assert property (ans |=> !ans)
    else $error("answer longer than one cycle");
  AST_CAP_ID: assert property (hdr_rd && ans |-> d[7:0] == 8'h10)
    else $error("capability identifier wrong");
  AST_NEXT_PTR: assert property (hdr_rd && ans |-> d[15:8] == 8'h00)
    else $error("next pointer not zero");
  AST_CAP_VER: assert property (hdr_rd && ans |-> d[19:16] == 4'h1)
    else $error("capability version wrong");
  AST_PORT_TYPE: assert property (hdr_rd && ans |->
    d[23:20] == (UPSTREAM ? 4'h5 : 4'h6)) else $error("port type wrong");
  AST_SLOT_UP: assert property (hdr_rd && ans && UPSTREAM |-> !d[24])
    else $error("slot bit set on upstream port");
  AST_MSG_NUM: assert property (hdr_rd && ans |-> d[29:25] == 5'h00)
    else $error("message number not zero");
  AST_DEV_FIXED: assert property (dev_rd && ans |-> d[11:3] == 9'h000)
    else $error("fixed device capability bits not zero");
  AST_POWER_DOWN: assert property (dev_rd && ans && !UPSTREAM |->
    d[27:18] == 10'h000) else $error("slot power set on downstream");
endmodule : pcer_regs_assertions

bind pcer_regs pcer_regs_assertions #(.UPSTREAM(UPSTREAM)) chk_u (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out)
);

// file: sim/pcer_eeprom_model.sv
// Behavioural serial EEPROM answering the bank's word frames
`timescale 1ns/10ps
module pcer_eeprom_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic nack_in,
  output logic sda_oe_out,
  output logic sda_out
);
  logic [15:0] mem [0:127];
  logic [4:0] cnt = 5'd0;
  logic [5:0] idle = 6'd0;
  logic scl_q = 1'b0;
  logic wr = 1'b0;
  logic [6:0] wa = 7'h00;
  logic [15:0] sh = 16'h0000;
  wire logic ack_slot = cnt == 5'd8 || cnt == 5'd25;
  initial begin
    sda_oe_out = 1'b0;
    sda_out = 1'b1;
    for (int i = 0; i < 128; i++) mem[i] = 16'h0000;
  end
  // Frame position restarts once the clock has stood still
  always @(posedge clk_in) begin
    scl_q <= scl_in;
    idle <= (scl_in != scl_q) ? 6'd0 : idle + {5'd0, idle != 6'd40};
    if (!rst_n_in || (idle == 6'd40 && scl_in == scl_q)) begin
      cnt <= 5'd0;
      sda_oe_out <= 1'b0;
    end else if (scl_in && !scl_q) begin
      cnt <= cnt + 5'd1;
      if (cnt == 5'd0) wr <= sda_in;
      if (cnt >= 5'd1 && cnt <= 5'd7) wa <= {wa[5:0], sda_in};
      if (cnt >= 5'd9 && cnt <= 5'd24) sh <= {sh[14:0], sda_in};
      if (cnt == 5'd24 && wr) mem[wa] <= {sh[14:0], sda_in};
    end else if (!scl_in && scl_q) begin
      sda_oe_out <= ack_slot ? !nack_in : (!wr && cnt >= 5'd9 && cnt <= 5'd24);
      sda_out <= ack_slot ? 1'b0 : mem[wa][5'd24 - cnt];
    end
  end
endmodule : pcer_eeprom_model

// file: sim/pcer_regs_tb.sv
// Self-checking bench for the capability and EEPROM register bank
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module pcer_regs_tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic pmsg = 1'b0;
  logic [7:0] pval = 8'h00;
  logic [1:0] pscale = 2'h0;
  logic nack = 1'b0;
  logic [3:0] be = 4'hf;
  logic strap = 1'b1;
  logic [31:0] rdata_u;
  logic [31:0] rdata_d;
  logic wait_u;
  logic wait_d;
  logic scl;
  logic sda_o;
  logic sda_oe;
  logic m_oe;
  logic m_val;
  int failures = 0;
  int comparisons = 0;
  // Pulled-up line
  wire logic sda_line = sda_oe ? sda_o : (m_oe ? m_val : 1'b1);
  always #4 clk_in = ~clk_in;
  pcer_regs #(.UPSTREAM(1'b1), .DIVIDE(8)) dut_u (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .avs_address_in(addr), .avs_read_in(rd_en),
    .avs_write_in(wr_en), .avs_byteenable_in(be),
    .avs_writedata_in(wdata), .slot_strap_in(strap), .power_msg_in(pmsg),
    .power_value_in(pval), .power_scale_in(pscale), .sda_in(sda_line),
    .avs_readdata_out(rdata_u), .avs_waitrequest_out(wait_u),
    .scl_out(scl), .sda_out(sda_o), .sda_oe_out(sda_oe));
  pcer_regs #(.UPSTREAM(1'b0), .DIVIDE(8)) dut_d (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .avs_address_in(addr), .avs_read_in(rd_en),
    .avs_write_in(wr_en), .avs_byteenable_in(be),
    .avs_writedata_in(wdata), .slot_strap_in(strap), .power_msg_in(pmsg),
    .power_value_in(pval), .power_scale_in(pscale), .sda_in(1'b1),
    .avs_readdata_out(rdata_d), .avs_waitrequest_out(wait_d),
    .scl_out(), .sda_out(), .sda_oe_out());
  pcer_eeprom_model ee_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .scl_in(scl), .sda_in(sda_line), .nack_in(nack),
    .sda_oe_out(m_oe), .sda_out(m_val));
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] qu, output logic [31:0] qd);
    int i;
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    rd_en <= !w;
    wr_en <= w;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_in);
      if (wait_u === 1'b0) break;
    end
    qu = rdata_u;
    qd = rdata_d;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    if (i == 50) failures++;
  endtask : bus
  task automatic ee(input logic [31:0] wd, output logic [31:0] res);
    logic [31:0] u;
    logic [31:0] d;
    int i;
    repeat (40) @(posedge clk_in);
    bus(1'b1, 8'hdc, wd, u, d);
    bus(1'b1, 8'hdc, 32'h00000000, u, d);
    bus(1'b0, 8'hdc, 32'h0, u, d);
    `CHK(u[15:0], wd[15:0])
    for (i = 0; i < 1000 && u[0] !== 1'b0; i++) bus(1'b0, 8'hdc, 32'h0, u, d);
    if (i == 1000) failures++;
    res = u;
  endtask : ee
  task automatic t_reset;
    logic [31:0] u;
    logic [31:0] d;
    bus(1'b0, 8'hdc, 32'h0, u, d);
    `CHK(u, 32'h00000000)
    `CHK(d, 32'h00000000)
    bus(1'b0, 8'he0, 32'h0, u, d);
    `CHK(u, 32'h00510010)
    `CHK(d, 32'h01610010)
    bus(1'b0, 8'he4, 32'h0, u, d);
    `CHK(u, 32'h00008001)
    `CHK(d, 32'h00008001)
    bus(1'b1, 8'he0, 32'hffffffff, u, d);
    bus(1'b0, 8'he0, 32'h0, u, d);
    `CHK(u, 32'h00510010)
    bus(1'b0, 8'h40, 32'h0, u, d);
    `CHK(u, 32'h00000000)
  endtask : t_reset
  task automatic t_eeprom;
    logic [31:0] r;
    ee(32'ha5c3aa03, r);
    `CHK(r, 32'ha5c3aa02)
    `CHK(ee_u.mem[7'h55], 16'ha5c3)
    nack <= 1'b1;
    ee(32'h00001001, r);
    `CHK(r[15:0], 16'h1004)
    nack <= 1'b0;
    ee_u.mem[7'h2a] = 16'h3c96;
    ee(32'hffff5401, r);
    `CHK(r, 32'h3c965400)
  endtask : t_eeprom
  task automatic t_override_power;
    logic [31:0] u;
    logic [31:0] d;
    bus(1'b1, 8'hf0, 32'h00000002, u, d);
    bus(1'b0, 8'he4, 32'h0, u, d);
    `CHK(u, 32'h00000002)
    bus(1'b0, 8'he0, 32'h0, u, d);
    `CHK(d, 32'h00610010)
    pval <= 8'h9b;
    pscale <= 2'h3;
    @(posedge clk_in);
    pmsg <= 1'b1;
    repeat (6) @(posedge clk_in);
    pmsg <= 1'b0;
    bus(1'b0, 8'he4, 32'h0, u, d);
    `CHK(u, 32'h0e6c0002)
    `CHK(d, 32'h00000002)
  endtask : t_override_power
  task automatic wrap_up;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    t_reset;
    t_eeprom;
    t_override_power;
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    wrap_up;
  end
endmodule : pcer_regs_tb
